/* secr_map.vh */
// Constants for the serial memory command front end
// Contract
// [R1] Decode latch set, clear, status read opcodes
// [R2] Status write: opcode then one byte
// [R3] Page write: opcode, address, 1-32 bytes
// [R4] Read: opcode, 16-bit address, data out
// [R5] Top three address bits ignored
// [R6] Sample input on rising edges 0-23
// [R7] Output data from falling edge 23
// [R8] Read address increments and wraps to zero
// [R9] Chip select high ends, output released
// [R10] Works in clock modes 0 and 3
// [R11] Page write completes within 5 ms
// [R12] Host sets latch before any write
// [R13] Over 32 bytes keeps last 32
// [R14] Programming starts on chip select rise
// [R15] Busy shown in status bit 0
// [R16] All bytes shifted most significant first
`ifndef SECR_MAP_VH
`define SECR_MAP_VH
`define SECR_OP_STATUS_WRITE_CMD_CMD 8'h01
`define SECR_OP_PAGE_WRITE 8'h02
`define SECR_OP_READ 8'h03
`define SECR_OP_LATCH_CLR 8'h04
`define SECR_OP_STATUS_RD 8'h05
`define SECR_OP_LATCH_SET 8'h06
`define SECR_ADDR_BITS 13
`define SECR_PAGE_BYTES 32
`define SECR_PAGE_BITS 5
`define SECR_CLK_NS 100
`define SECR_WRITE_NS 5000000
`define SECR_WRITE_CYC (`SECR_WRITE_NS / `SECR_CLK_NS)
`define SECR_ST_BUSY 0
`define SECR_ST_WEN 1
`endif

/* secr_sync.v */
// Two-stage synchroniser for the serial pins
`timescale 1ns/100ps
module secr_sync #(
    parameter WIDTH = 3
) (
    input wire i_core_clk,
    input wire i_resetn,
    input wire [WIDTH-1:0] i_async,
    input wire [WIDTH-1:0] i_reset_val,
    output reg [WIDTH-1:0] o_sync
);
    reg [WIDTH-1:0] stage1;
    // Reset value is all ones; the i_reset_val port is not used
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            stage1 <= {WIDTH{1'b1}};
            o_sync <= {WIDTH{1'b1}};
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

/* secr_top.v */
// Serial memory command front end with read path and write framing
`timescale 1ns/100ps
`include "secr_map.vh"
module secr_top #(
    parameter WRITE_CYC = `SECR_WRITE_CYC,
    parameter AW = `SECR_ADDR_BITS
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_resetn,
    // Serial pins
    input wire i_cs_n,
    input wire i_sck,
    input wire i_si,
    output reg o_so,
    output reg o_so_oe,
    // Memory array port
    output reg [AW-1:0] o_mem_addr,
    output reg o_mem_rd,
    input wire [7:0] i_mem_rdata,
    output reg o_mem_wr,
    output reg [AW-1:0] o_mem_waddr,
    output reg [7:0] o_mem_wdata,
    // Status register write port and read data
    output reg o_stat_wr,
    output reg [7:0] o_stat_wdata,
    input wire [7:0] i_stat_rdata,
    // State
    output reg o_busy,
    output reg o_wen
);
    // ------------------------------------------------------------
    // Command phase and programming sequencer states
    // ------------------------------------------------------------
    localparam ST_OPC = 6'b000001;
    localparam ST_ADDR = 6'b000010;
    localparam ST_RDATA = 6'b000100;
    localparam ST_PDATA = 6'b001000;
    localparam ST_SDATA = 6'b010000;
    localparam ST_IGN = 6'b100000;
    localparam ST_IDLE = 2'b01;
    localparam ST_PROG = 2'b10;

    function is_op;
        input [7:0] val;
        input [7:0] op;
        begin
            is_op = (val == op);
        end
    endfunction

    wire cs_n_s;
    wire sck_s;
    wire si_s;
    reg sck_d;
    reg cs_d;
    reg [5:0] state;
    reg [1:0] pstate;
    reg [2:0] bitcnt;
    reg [7:0] shreg;
    reg [7:0] opcode;
    reg addr_hi_done;
    reg [7:0] addr_hi;
    reg [AW-1:0] addr;
    reg [7:0] txreg;
    reg [7:0] page [0:`SECR_PAGE_BYTES-1];
    reg [`SECR_PAGE_BITS-1:0] wr_ptr;
    reg [`SECR_PAGE_BITS:0] nbytes;
    reg sbyte_ok;
    reg [7:0] sbyte;
    reg pend_page;
    reg pend_stat;
    reg [31:0] prog_cnt;
    reg [`SECR_PAGE_BITS:0] prog_idx;
    reg [AW-1:0] prog_base;
    wire sck_rise;
    wire sck_fall;
    wire cs_rise;
    wire [7:0] next_shreg;
    wire byte_done;
    wire [7:0] status;
    integer k;

    secr_sync #(
        .WIDTH(3)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_async({i_cs_n, i_sck, i_si}),
        .i_reset_val(3'h7),
        .o_sync({cs_n_s, sck_s, si_s})
    );

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    // [R10] Mode 0 and 3
    // Edges counted only while selected, so idle level is irrelevant
    assign sck_rise = !cs_n_s && sck_s && !sck_d;
    assign sck_fall = !cs_n_s && !sck_s && sck_d;
    assign cs_rise = cs_n_s && !cs_d;
    // [R16] MSB first in
    assign next_shreg = {shreg[6:0], si_s};
    assign byte_done = sck_rise && (bitcnt == 3'h7);
    assign status = {i_stat_rdata[7:2], o_wen, o_busy};

    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sck_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sck_d <= sck_s;
            cs_d <= cs_n_s;
        end
    end

    // ------------------------------------------------------------
    // Serial command engine
    // ------------------------------------------------------------
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_OPC;
            bitcnt <= 3'h0;
            shreg <= 8'h00;
            opcode <= 8'h00;
            addr_hi_done <= 1'b0;
            addr_hi <= 8'h00;
            addr <= {AW{1'b0}};
            txreg <= 8'h00;
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
            o_mem_addr <= {AW{1'b0}};
            o_mem_rd <= 1'b0;
            wr_ptr <= {`SECR_PAGE_BITS{1'b0}};
            nbytes <= {(`SECR_PAGE_BITS+1){1'b0}};
            sbyte_ok <= 1'b0;
            sbyte <= 8'h00;
            for (k = 0; k < `SECR_PAGE_BYTES; k = k + 1) begin
                page[k] <= 8'h00;
            end
        end else if (cs_n_s) begin
            // [R9] Deselect ends command
            state <= ST_OPC;
            bitcnt <= 3'h0;
            addr_hi_done <= 1'b0;
            o_so_oe <= 1'b0;
            o_mem_rd <= 1'b0;
        end else begin
            o_mem_rd <= 1'b0;
            if (sck_rise) begin
                // [R6] Sample on rise
                shreg <= next_shreg;
                bitcnt <= bitcnt + 3'h1;
                if (bitcnt != 3'h7) begin
                    // Partial bytes void a pending status byte
                    sbyte_ok <= sbyte_ok && (state != ST_SDATA);
                end
            end
            if (byte_done) begin
                case (state)
                    ST_OPC: begin
                        opcode <= next_shreg;
                        wr_ptr <= {`SECR_PAGE_BITS{1'b0}};
                        nbytes <= {(`SECR_PAGE_BITS+1){1'b0}};
                        sbyte_ok <= 1'b0;
                        // [R1] Single byte opcodes
                        if (is_op(next_shreg, `SECR_OP_STATUS_RD)) begin
                            state <= ST_RDATA;
                        end else if (is_op(next_shreg, `SECR_OP_READ) ||
                                is_op(next_shreg, `SECR_OP_PAGE_WRITE)) begin
                            state <= ST_ADDR;
                        end else if (is_op(next_shreg,
                                `SECR_OP_STATUS_WRITE_CMD_CMD)) begin
                            state <= ST_SDATA;
                        end else begin
                            state <= ST_IGN;
                        end
                    end
                    ST_ADDR: begin
                        if (!addr_hi_done) begin
                            addr_hi <= next_shreg;
                            addr_hi_done <= 1'b1;
                        end else begin
                            // [R5] Drop top three bits
                            addr <= {addr_hi[AW-9:0], next_shreg};
                            o_mem_addr <= {addr_hi[AW-9:0], next_shreg};
                            o_mem_rd <= is_op(opcode, `SECR_OP_READ);
                            // [R4] Read data follows address
                            state <= is_op(opcode, `SECR_OP_READ) ?
                                ST_RDATA : ST_PDATA;
                        end
                    end
                    ST_PDATA: begin
                        // [R3] Whole data bytes only
                        // [R13] Ring keeps last 32 bytes
                        page[wr_ptr] <= next_shreg;
                        wr_ptr <= wr_ptr + 1'b1;
                        if (nbytes != `SECR_PAGE_BYTES) begin
                            nbytes <= nbytes + 1'b1;
                        end
                    end
                    ST_SDATA: begin
                        // [R2] Exactly one data byte
                        sbyte <= next_shreg;
                        sbyte_ok <= (nbytes == 0);
                        nbytes <= nbytes + 1'b1;
                    end
                    ST_RDATA: begin
                        if (is_op(opcode, `SECR_OP_READ)) begin
                            // [R8] Increment, wrap at top
                            addr <= addr + 1'b1;
                            o_mem_addr <= addr + 1'b1;
                            o_mem_rd <= 1'b1;
                        end
                    end
                    default: begin
                        state <= ST_IGN;
                    end
                endcase
            end
            if (sck_fall && state == ST_RDATA) begin
                // [R7] Drive on falling edges
                o_so_oe <= 1'b1;
                if (bitcnt == 3'h0) begin
                    // [R16] MSB first out
                    o_so <= is_op(opcode, `SECR_OP_READ) ?
                        i_mem_rdata[7] : status[7];
                    txreg <= is_op(opcode, `SECR_OP_READ) ?
                        {i_mem_rdata[6:0], 1'b0} : {status[6:0], 1'b0};
                end else begin
                    o_so <= txreg[7];
                    txreg <= {txreg[6:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Write latch and programming sequencer
    // ------------------------------------------------------------
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wen <= 1'b0;
            o_busy <= 1'b0;
            pstate <= ST_IDLE;
            pend_page <= 1'b0;
            pend_stat <= 1'b0;
            prog_cnt <= 32'h0;
            prog_idx <= {(`SECR_PAGE_BITS+1){1'b0}};
            prog_base <= {AW{1'b0}};
            o_mem_wr <= 1'b0;
            o_mem_waddr <= {AW{1'b0}};
            o_mem_wdata <= 8'h00;
            o_stat_wr <= 1'b0;
            o_stat_wdata <= 8'h00;
        end else begin
            o_mem_wr <= 1'b0;
            o_stat_wr <= 1'b0;
            pend_page <= 1'b0;
            pend_stat <= 1'b0;
            case (pstate)
                ST_IDLE: begin
                    if (cs_rise && bitcnt == 3'h0 && state != ST_OPC) begin
                        // [R1] Latch set and clear
                        if (is_op(opcode, `SECR_OP_LATCH_SET)) begin
                            o_wen <= 1'b1;
                        end else if (is_op(opcode, `SECR_OP_LATCH_CLR)) begin
                            o_wen <= 1'b0;
                        // [R14] Start on select rise
                        // [R12] Refused unless latch set
                        end else if (o_wen && state == ST_PDATA &&
                                nbytes != 0) begin
                            pstate <= ST_PROG;
                            o_busy <= 1'b1;
                            prog_cnt <= 32'h0;
                            prog_idx <= {(`SECR_PAGE_BITS+1){1'b0}};
                            prog_base <= addr;
                            pend_page <= 1'b1;
                        end else if (o_wen && state == ST_SDATA &&
                                sbyte_ok) begin
                            pstate <= ST_PROG;
                            o_busy <= 1'b1;
                            prog_cnt <= 32'h0;
                            pend_stat <= 1'b1;
                        end
                    end
                end
                ST_PROG: begin
                    // [R15] Busy while programming
                    // [R11] Bounded write time
                    prog_cnt <= prog_cnt + 32'h1;
                    if (pend_stat) begin
                        o_stat_wr <= 1'b1;
                        o_stat_wdata <= sbyte;
                    end
                    if (prog_idx < nbytes && opcode == `SECR_OP_PAGE_WRITE) begin
                        o_mem_wr <= 1'b1;
                        // Oldest byte sits at write pointer once full
                        o_mem_waddr <= prog_base +
                            {{(AW-`SECR_PAGE_BITS-1){1'b0}}, prog_idx};
                        o_mem_wdata <= page[(nbytes == `SECR_PAGE_BYTES) ?
                            wr_ptr + prog_idx[`SECR_PAGE_BITS-1:0] :
                            prog_idx[`SECR_PAGE_BITS-1:0]];
                        prog_idx <= prog_idx + 1'b1;
                    end
                    if (prog_cnt >= WRITE_CYC - 1) begin
                        pstate <= ST_IDLE;
                        o_busy <= 1'b0;
                        o_wen <= 1'b0;
                    end
                end
                default: begin
                    pstate <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* secr_top_properties.sv */
// Assertion checker for the serial memory command front end
`timescale 1ns/100ps
module secr_top_properties #(
    parameter WRITE_CYC = 50000
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_resetn,
    // Pins and state
    input wire i_cs_n,
    input wire i_sck,
    input wire o_so,
    input wire o_so_oe,
    input wire o_stat_wr,
    input wire o_busy,
    input wire o_wen
);
    default clocking dc @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    // Busy span counted, too long to unroll
    int bcnt;
    always @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            bcnt <= 0;
        end else begin
            bcnt <= o_busy ? bcnt + 1 : 0;
        end
    end
    AST_OE_OFF: assert property ($rose(i_cs_n) |-> ##[1:4] !o_so_oe)
        else $error("output still driven after deselect");
    AST_OE_IDLE: assert property (i_cs_n [*5] |-> !o_so_oe)
        else $error("output driven while deselected");
    AST_SO_FALL: assert property (
        o_so_oe && $past(o_so_oe) && !i_cs_n && $changed(o_so)
        |-> !$past(i_sck, 3))
        else $error("output bit changed away from a falling edge");
    AST_BUSY_MIN: assert property ($rose(o_busy) |-> o_busy [*8])
        else $error("busy dropped too early");
    AST_BUSY_MAX: assert property (bcnt <= WRITE_CYC)
        else $error("write cycle ran too long");
    AST_BUSY_DESEL: assert property (
        $rose(o_busy) |-> i_cs_n && $past(i_cs_n, 2))
        else $error("programming started while selected");
    AST_WEN_SET: assert property ($rose(o_wen) |-> i_cs_n && !o_busy)
        else $error("latch set at the wrong moment");
    AST_WEN_END: assert property ($fell(o_busy) |-> ##[0:1] !o_wen)
        else $error("latch not cleared after write cycle");
    AST_STAT_PULSE: assert property (o_stat_wr |=> !o_stat_wr)
        else $error("status write longer than one cycle");
    COV_READ: cover property ($rose(o_so_oe));
    COV_WRITE: cover property ($fell(o_busy));
    COV_STAT: cover property (o_stat_wr);
    COV_CLR: cover property ($fell(o_wen) && !o_busy);
endmodule

/* secr_host_model.sv */
// Host controller model driving the serial pins
`timescale 1ns/100ps
module secr_host_model (
    // Clock and returned data
    input wire i_core_clk,
    input wire i_so,
    // Serial pins
    output logic o_cs_n,
    output logic o_sck,
    output logic o_si
);
    logic [7:0] tx [40];
    logic [7:0] rx [40];
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        foreach (tx[j]) tx[j] = 8'h00;
    end
    // Unselected data line toggles, never a stale value
    always @(negedge i_core_clk) begin
        if (o_cs_n) o_si <= ~o_si;
    end
    task automatic run(input bit m3, input int n);
        int i;
        int b;
        o_sck = m3;
        repeat (2) @(negedge i_core_clk);
        o_cs_n = 1'b0;
        repeat (4) @(negedge i_core_clk);
        for (i = 0; i < n; i++) begin
            for (b = 7; b >= 0; b--) begin
                o_sck = 1'b0;
                o_si = tx[i][b];
                repeat (4) @(negedge i_core_clk);
                o_sck = 1'b1;
                repeat (4) @(negedge i_core_clk);
                rx[i][b] = i_so;
            end
        end
        o_sck = m3;
        repeat (4) @(negedge i_core_clk);
        o_cs_n = 1'b1;
        repeat (8) @(negedge i_core_clk);
    endtask
endmodule

/* tb_secr_top.sv */
// Self-checking testbench for the serial memory command front end
`timescale 1ns/100ps
module tb_secr_top;
    localparam int WCYC = 400;
    typedef struct {logic [15:0] a; bit m3;} secr_row_t;
    secr_row_t rows [4] = '{'{16'h0000, 1'b0}, '{16'he123, 1'b1},
                            '{16'hffff, 1'b0}, '{16'h0abc, 1'b1}};
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] stat = 8'ha4;
    logic so_last = 1'b0;
    logic [7:0] sdat;
    logic [12:0] wa [64];
    logic [7:0] wd [64];
    wire cs_n, sck, si, so_w, o_so, o_so_oe, o_mem_rd, o_mem_wr;
    wire o_stat_wr, o_busy, o_wen;
    wire [12:0] o_mem_addr, o_mem_waddr;
    wire [7:0] o_mem_wdata, o_stat_wdata, rdata;
    int n_fail = 0, checks = 0, nwr = 0, nst = 0, bcnt = 0, blen = 0, i, k;
    function automatic logic [7:0] memv(input logic [12:0] a);
        return a[7:0] ^ {a[12:8], 3'h5};
    endfunction
    assign rdata = memv(o_mem_addr);
    // Released line shows the inverse of its last level
    assign so_w = o_so_oe ? o_so : ~so_last;
    always #50 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        if (o_so_oe) so_last <= o_so;
        if (o_busy) begin
            bcnt <= bcnt + 1;
        end else if (bcnt != 0) begin
            blen <= bcnt;
            bcnt <= 0;
        end
        if (o_mem_wr && nwr < 64) begin
            wa[nwr] <= o_mem_waddr;
            wd[nwr] <= o_mem_wdata;
            nwr <= nwr + 1;
        end
        if (o_stat_wr) begin
            sdat <= o_stat_wdata;
            nst <= nst + 1;
        end
    end
    secr_host_model host (.i_core_clk(i_core_clk), .i_so(so_w),
        .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
    secr_top #(.WRITE_CYC(WCYC)) uut (
        .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cs_n(cs_n),
        .i_sck(sck), .i_si(si), .o_so(o_so), .o_so_oe(o_so_oe),
        .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd), .i_mem_rdata(rdata),
        .o_mem_wr(o_mem_wr), .o_mem_waddr(o_mem_waddr),
        .o_mem_wdata(o_mem_wdata), .o_stat_wr(o_stat_wr),
        .o_stat_wdata(o_stat_wdata), .i_stat_rdata(stat),
        .o_busy(o_busy), .o_wen(o_wen));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic send(input bit m3, input int n, input logic [7:0] b0,
                        input logic [7:0] b1, input logic [7:0] b2);
        host.tx[0] = b0;
        host.tx[1] = b1;
        host.tx[2] = b2;
        host.run(m3, n);
    endtask
    task automatic wait_idle();
        for (k = 0; k < WCYC + 40 && o_busy === 1'b1; k++)
            @(negedge i_core_clk);
        repeat (2) @(negedge i_core_clk);
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (3) @(negedge i_core_clk);
        chk({o_so_oe, o_busy, o_wen, o_mem_wr, o_stat_wr}, 0);
        repeat (9) @(negedge i_core_clk);
        i_resetn = 1'b1;
        repeat (4) @(negedge i_core_clk);
        // Reads in both modes, high bits dropped, wrap at the top
        for (i = 0; i < 4; i++) begin
            send(rows[i].m3, 5, 8'h03, rows[i].a[15:8], rows[i].a[7:0]);
            chk(host.rx[3], memv(rows[i].a[12:0]));
            chk(host.rx[4], memv(rows[i].a[12:0] + 13'h1));
            chk(o_so_oe, 1'b0);
        end
        host.tx[3] = 8'h11;
        send(1'b0, 4, 8'h02, 8'h00, 8'h10);
        chk(nwr, 0);
        send(1'b0, 1, 8'h06, 8'h00, 8'h00);
        chk(o_wen, 1'b1);
        send(1'b1, 1, 8'h04, 8'h00, 8'h00);
        chk(o_wen, 1'b0);
        send(1'b1, 1, 8'h06, 8'h00, 8'h00);
        send(1'b0, 2, 8'h05, 8'h00, 8'h00);
        chk(host.rx[1], {stat[7:2], 2'b10});
        host.tx[3] = 8'ha1;
        host.tx[4] = 8'hb2;
        host.tx[5] = 8'hc3;
        send(1'b0, 6, 8'h02, 8'hff, 8'hfe);
        chk(o_busy, 1'b1);
        send(1'b1, 2, 8'h05, 8'h00, 8'h00);
        chk(host.rx[1][0], 1'b1);
        wait_idle();
        chk(blen, WCYC);
        chk(o_wen, 1'b0);
        chk(nwr, 3);
        chk({wa[0], wd[0]}, {13'h1ffe, 8'ha1});
        chk({wa[2], wd[2]}, {13'h0000, 8'hc3});
        // Overlong page keeps only its last bytes
        nwr = 0;
        for (i = 3; i < 37; i++) host.tx[i] = i[7:0];
        send(1'b0, 1, 8'h06, 8'h00, 8'h00);
        send(1'b0, 37, 8'h02, 8'h00, 8'h40);
        wait_idle();
        chk(nwr, 32);
        chk({wa[0], wd[0]}, {13'h0040, 8'h05});
        chk({wa[31], wd[31]}, {13'h005f, 8'h24});
        send(1'b0, 1, 8'h06, 8'h00, 8'h00);
        send(1'b0, 2, 8'h01, 8'h5c, 8'h00);
        wait_idle();
        chk({nst[7:0], sdat}, 16'h015c);
        send(1'b0, 1, 8'h06, 8'h00, 8'h00);
        send(1'b0, 3, 8'h01, 8'h33, 8'h44);
        wait_idle();
        chk(nst, 1);
        give_verdict();
    end
endmodule
bind secr_top secr_top_properties #(.WRITE_CYC(WRITE_CYC)) u_props (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n),
    .i_sck(i_sck), .o_so(o_so), .o_so_oe(o_so_oe),
    .o_stat_wr(o_stat_wr), .o_busy(o_busy), .o_wen(o_wen));
